/* File: verilog/ccd_channel_divider.v */
// cascaded two-stage channel dividers with coarse phase and duty correction
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "ccd_map.vh"

module ccd_channel_divider #(
   parameter ADDR_W = 12                       // apb byte address width
) (
   input  wire              clk,               // system clock, 250 MHz
   input  wire              srst,              // synchronous reset, active high
   input  wire              psel,              // apb select
   input  wire              penable,           // apb access phase
   input  wire              pwrite,            // apb direction, high = write
   input  wire [ADDR_W-1:0] paddr,             // apb byte address
   input  wire [31:0]       pwdata,            // apb write data
   output reg  [31:0]       prdata,            // apb read data
   output wire              pready,            // apb ready, zero wait
   output wire              pslverr,           // apb error on unmapped access
   input  wire [1:0]        chInClk,           // channel input clock levels
   input  wire              syncHold,          // sync held while high
   output reg  [1:0]        chOut              // channel outputs to drivers
);

   // ----------------------------------------------------------------
   // configuration storage
   // ----------------------------------------------------------------
   reg  [7:0] division [0:3];                  // stage division, ch3.1 ch3.2 ch4.1 ch4.2
   reg  [7:0] phaseCodes [0:1];                // phase nibbles per channel
   reg  [7:0] startBypass [0:1];               // start levels and bypass bits
   reg  [7:0] dutyFixDisable [0:1];            // correction disable per channel

   // stage datapath nets
   wire [3:0] stIn;                            // clock entering each stage
   wire [3:0] stOut;                           // clock leaving each stage
   wire [3:0] stLevel;                         // counter output level
   wire [3:0] stPrevIn;                        // previous input sample

   // apb decode nets
   wire [ADDR_W-3:0] regIdx;                   // word index from address
   wire              accessPh;                 // access phase of a transfer
   wire              setupPh;                  // setup phase of a transfer
   wire              hit;                      // address maps to a register

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // true when the word index names a register
   function isMapped;
      input [ADDR_W-3:0] idx;
      begin
         case (idx)
            `CCD_IDX_CH3_STAGE1_DIVISION,
            `CCD_IDX_CH3_PHASE_CODES,
            `CCD_IDX_CH3_STAGE2_DIVISION,
            `CCD_IDX_CH3_START_LEVEL_BYPASS,
            `CCD_IDX_CH3_DUTY_FIX_DISABLE,
            `CCD_IDX_CH4_STAGE1_DIVISION,
            `CCD_IDX_CH4_PHASE_CODES,
            `CCD_IDX_CH4_STAGE2_DIVISION,
            `CCD_IDX_CH4_START_LEVEL_BYPASS,
            `CCD_IDX_CH4_DUTY_FIX_DISABLE,
            `CCD_IDX_STATUS: isMapped = 1'b1;
            default:         isMapped = 1'b0;
         endcase
      end
   endfunction

   // low nibble widened to counter width
   function [4:0] widen;
      input [3:0] v;
      begin
         widen = {1'b0, v};
      end
   endfunction

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign regIdx   = paddr[ADDR_W-1:2];
   assign setupPh  = psel & ~penable;
   assign accessPh = psel & penable;
   assign hit      = isMapped(regIdx) & (paddr[1:0] == 2'h0);
   assign pready   = 1'b1;                     // every access ends at once
   assign pslverr  = accessPh & ~hit;          // unmapped or misaligned

   // register writes in the access phase
   always @(posedge clk) begin
      if (srst) begin
         division[0]       <= `CCD_RST_DIVISION;
         division[1]       <= `CCD_RST_DIVISION;
         division[2]       <= `CCD_RST_DIVISION;
         division[3]       <= `CCD_RST_DIVISION;
         phaseCodes[0]     <= `CCD_RST_PHASE;
         phaseCodes[1]     <= `CCD_RST_PHASE;
         startBypass[0]    <= `CCD_RST_START_BYP;
         startBypass[1]    <= `CCD_RST_START_BYP;
         dutyFixDisable[0] <= `CCD_RST_DUTY_FIX;  // RULE16
         dutyFixDisable[1] <= `CCD_RST_DUTY_FIX;  // RULE16
      end else if (accessPh & pwrite & hit) begin
         case (regIdx)
            // low count 7:4, high count 3:0 per stage
            `CCD_IDX_CH3_STAGE1_DIVISION:    division[0]       <= pwdata[7:0]; // RULE4
            `CCD_IDX_CH3_STAGE2_DIVISION:    division[1]       <= pwdata[7:0]; // RULE4
            `CCD_IDX_CH4_STAGE1_DIVISION:    division[2]       <= pwdata[7:0]; // RULE4
            `CCD_IDX_CH4_STAGE2_DIVISION:    division[3]       <= pwdata[7:0]; // RULE4
            // stage phase nibbles, low half first stage
            `CCD_IDX_CH3_PHASE_CODES:        phaseCodes[0]     <= pwdata[7:0]; // RULE3
            `CCD_IDX_CH4_PHASE_CODES:        phaseCodes[1]     <= pwdata[7:0]; // RULE3
            // start levels and bypass bits
            `CCD_IDX_CH3_START_LEVEL_BYPASS: startBypass[0]    <= pwdata[7:0]; // RULE3
            `CCD_IDX_CH4_START_LEVEL_BYPASS: startBypass[1]    <= pwdata[7:0]; // RULE3
            // correction disable bits
            `CCD_IDX_CH3_DUTY_FIX_DISABLE:   dutyFixDisable[0] <= pwdata[7:0]; // RULE16
            `CCD_IDX_CH4_DUTY_FIX_DISABLE:   dutyFixDisable[1] <= pwdata[7:0]; // RULE16
            default: ;                         // status is read only
         endcase
      end
   end

   // read data captured in the setup phase, valid through the access
   always @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h00000000;
      end else if (setupPh & ~hit) begin
         // refused reads, misaligned ones too, return zero
         prdata <= 32'h00000000;
      end else if (setupPh) begin
         case (regIdx)
            `CCD_IDX_CH3_STAGE1_DIVISION:    prdata <= {24'h000000, division[0]};
            `CCD_IDX_CH3_PHASE_CODES:        prdata <= {24'h000000, phaseCodes[0]};
            `CCD_IDX_CH3_STAGE2_DIVISION:    prdata <= {24'h000000, division[1]};
            `CCD_IDX_CH3_START_LEVEL_BYPASS: prdata <= {24'h000000, startBypass[0]};
            `CCD_IDX_CH3_DUTY_FIX_DISABLE:   prdata <= {24'h000000, dutyFixDisable[0]};
            `CCD_IDX_CH4_STAGE1_DIVISION:    prdata <= {24'h000000, division[2]};
            `CCD_IDX_CH4_PHASE_CODES:        prdata <= {24'h000000, phaseCodes[1]};
            `CCD_IDX_CH4_STAGE2_DIVISION:    prdata <= {24'h000000, division[3]};
            `CCD_IDX_CH4_START_LEVEL_BYPASS: prdata <= {24'h000000, startBypass[1]};
            `CCD_IDX_CH4_DUTY_FIX_DISABLE:   prdata <= {24'h000000, dutyFixDisable[1]};
            // live state: stage levels, sync, outputs
            `CCD_IDX_STATUS: prdata <= {25'h0000000, chOut, syncHold, stLevel};
            default:         prdata <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // stage chain: four counters, two per channel
   // ----------------------------------------------------------------
   genvar s;
   generate
      for (s = 0; s < 4; s = s + 1) begin : g_stage
         // per-stage configuration slices
         wire [3:0] lowCnt;                    // low cycles minus one
         wire [3:0] highCnt;                   // high cycles minus one
         wire [3:0] phaseStep;                 // phase step nibble
         wire       startLevel;                // start level bit
         wire       bypass;                    // stage passes input through
         wire       dutyFixOn;                 // correction active
         wire       oddSplit;                  // low count one above high
         wire       rise;                      // input rising edge
         wire       fall;                      // input falling edge
         wire [4:0] phaseCode;                 // five-bit phase code
         reg  [4:0] cnt;                       // cycles left in current level
         reg        pendFall;                  // corrected fall awaits input fall
         reg        level;                     // this stage's counter level
         reg        prevIn;                    // this stage's input one clk ago

         assign lowCnt     = division[s][`CCD_LOW_CNT_LSB +: 4];          // RULE4
         assign highCnt    = division[s][`CCD_HIGH_CNT_LSB +: 4];         // RULE4
         assign phaseStep  = phaseCodes[s/2][(s%2)*`CCD_PHASE_STEP_W +: 4]; // RULE3
         assign startLevel = startBypass[s/2][`CCD_START_LEVEL_LSB + s%2]; // RULE3
         assign bypass     = startBypass[s/2][`CCD_BYPASS_LSB + s%2];
         assign dutyFixOn  = ~dutyFixDisable[s/2][`CCD_DUTY_FIX_BIT];    // RULE16
         assign oddSplit   = (widen(highCnt) + 5'h01) == widen(lowCnt);
         assign phaseCode  = {startLevel, phaseStep};                    // RULE2

         // first stage takes the channel clock, second the first output
         if (s % 2 == 0) begin : g_first
            assign stIn[s] = chInClk[s/2];                              // RULE5
         end else begin : g_second
            assign stIn[s] = stOut[s-1];                                // RULE5
         end

         // per-stage flops gathered into the shared vectors
         assign stLevel[s]  = level;
         assign stPrevIn[s] = prevIn;

         assign rise = stIn[s] & ~stPrevIn[s];
         assign fall = ~stIn[s] & stPrevIn[s];

         // bypassed stage passes the input waveform unchanged
         assign stOut[s] = bypass ? stIn[s] : stLevel[s];                // RULE12

         // counter: preset under sync, count input periods after release
         always @(posedge clk) begin
            if (srst) begin
               level    <= 1'b0;
               prevIn   <= 1'b0;
               cnt      <= 5'h00;
               pendFall <= 1'b0;
            end else begin
               prevIn <= stIn[s];
               if (syncHold) begin
                  // static preset; delay measured from release
                  pendFall <= 1'b0;                                     // RULE17
                  if (phaseCode < `CCD_CODE_HIGH_W) begin
                     // start low: phase steps plus low cycles
                     level <= 1'b0;                                     // RULE6
                     cnt   <= widen(phaseStep) + widen(lowCnt);         // RULE1
                  end else begin
                     // start high: held high for code-16+low+1 periods
                     level <= 1'b1;                                     // RULE7
                     cnt   <= widen(phaseCode[3:0]) + widen(lowCnt);    // RULE8
                  end
               end else if (rise) begin
                  if (cnt != 5'h00) begin
                     cnt <= cnt - 5'h01;                                // RULE14
                  end else if (level == 1'b0) begin
                     // low phase over: go high for high+1
                     level <= 1'b1;
                     cnt   <= widen(highCnt);                           // RULE14
                  end else if (dutyFixOn & oddSplit & ~pendFall) begin
                     // odd split: hold high into next input low half
                     pendFall <= 1'b1;                                  // RULE13
                     cnt      <= widen(lowCnt);                         // RULE11
                  end else begin
                     // high phase over: go low for low+1
                     level <= 1'b0;
                     cnt   <= widen(lowCnt);                            // RULE14
                  end
               end else if (fall & pendFall) begin
                  // corrected fall at mid input period
                  level      <= 1'b0;                                   // RULE10
                  pendFall   <= 1'b0;                                   // RULE13
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // output registers toward the drivers
   // ----------------------------------------------------------------

   // channel output is the second stage result, registered
   always @(posedge clk) begin
      if (srst) begin
         chOut <= 2'h0;
      end else begin
         // both stage delays have already added up in the cascade
         chOut <= {stOut[3], stOut[1]};                                 // RULE9
      end
   end

endmodule
`default_nettype wire

/* File: verilog/ccd_map.vh */
// register map, field positions and reset values of the cascaded channel divider
// Summary of operation
// RULE1: each divider offers whole-period coarse phase delay
// RULE2: phase code is start level times 16 plus nibble
// RULE3: start levels bits 0/1; nibbles low/high phase
// RULE4: low count bits 7:4, high count 3:0
// RULE5: stage delays count that stage's input periods
// RULE6: both codes small: codes times periods add
// RULE7: second code large: adds code-16+low+1 periods
// RULE8: first code large: adds code-16+low+1 periods
// RULE9: both large: both stages add their terms
// RULE10: correction with even input gives fifty percent
// RULE11: odd prescaler: odd-only stages follow input duty
// RULE12: both bypassed: input duty passes straight through
// RULE13: any even stage or fifty input: fifty
// RULE14: low for low+1, high for high+1 cycles
// RULE15: software uses first stage, bypasses second only
// RULE16: correction on by default, off by disable bit
// RULE17: sync release presets start level and phase
`ifndef CCD_MAP_VH
`define CCD_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CCD_IDX_CH3_STAGE1_DIVISION     12'h199
`define CCD_IDX_CH3_PHASE_CODES         12'h19a
`define CCD_IDX_CH3_STAGE2_DIVISION     12'h19b
`define CCD_IDX_CH3_START_LEVEL_BYPASS  12'h19c
`define CCD_IDX_CH3_DUTY_FIX_DISABLE    12'h19d
`define CCD_IDX_CH4_STAGE1_DIVISION     12'h19e
`define CCD_IDX_CH4_PHASE_CODES         12'h19f
`define CCD_IDX_CH4_STAGE2_DIVISION     12'h1a0
`define CCD_IDX_CH4_START_LEVEL_BYPASS  12'h1a1
`define CCD_IDX_CH4_DUTY_FIX_DISABLE    12'h1a2
`define CCD_IDX_STATUS                  12'h1a4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCD_LOW_CNT_LSB      4
`define CCD_HIGH_CNT_LSB     0
`define CCD_START_LEVEL_LSB  0
`define CCD_BYPASS_LSB       4
`define CCD_PHASE_STEP_W     4
`define CCD_DUTY_FIX_BIT     0

// ----------------------------------------------------------------
// reset values and code thresholds
// ----------------------------------------------------------------
`define CCD_RST_DIVISION     8'h00
`define CCD_RST_PHASE        8'h00
`define CCD_RST_START_BYP    8'h00
`define CCD_RST_DUTY_FIX     8'h00
`define CCD_CODE_HIGH_W      5'h10

`endif

/* File: testbench/ccd_channel_divider_chk.sv */
// port assertions for the cascaded channel divider
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module ccd_channel_divider_chk #(
   parameter ADDR_W = 12                    // apb byte address width
) (
   input wire logic              clk,
   input wire logic              srst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [1:0]        chInClk,
   input wire logic              syncHold,
   input wire logic [1:0]        chOut
);
   logic       mapOk;                       // aligned and decoded address
   logic [7:0] lastPh;                      // shadow of ch3 phase register
   logic       lastIn;                      // ch3 input level one clk ago
   logic [3:0] sinceIn;                     // clks since last ch3 input edge

   // decoded window: 0x199..0x1a2 and status 0x1a4, word aligned
   assign mapOk = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:2] == 10'h1a4 ||
                  (paddr[ADDR_W-1:2] >= 10'h199 && paddr[ADDR_W-1:2] <= 10'h1a2));

   // shadow register and input edge age
   always @(posedge clk) begin
      lastIn <= chInClk[0];
      if (srst) begin
         lastPh  <= 8'h00;
         sinceIn <= 4'hf;
      end else begin
         if (psel && penable && pwrite && paddr == 12'h668) begin
            lastPh <= pwdata[7:0];
         end
         sinceIn <= (chInClk[0] != lastIn) ? 4'h0 : ((sinceIn == 4'hf) ? 4'hf : sinceIn + 4'h1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_ready_access: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   chk_err_decode: assert property (psel && penable |-> pslverr == !mapOk)
      else $error("pslverr does not match address decode");
   chk_rdata_upper: assert property (psel && penable |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chk_refused_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   chk_rdata_stands: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data changed outside setup");
   chk_phase_back: assert property (psel && penable && !pwrite && paddr == 12'h668 |->
      prdata[7:0] == lastPh)
      else $error("phase register readback wrong");
   chk_reset_clear: assert property ($fell(srst) |-> chOut == 2'b00 && prdata == 32'h0)
      else $error("outputs not cleared by reset");
   chk_out_cause: assert property (!syncHold && !$past(syncHold) && chOut[0] != $past(chOut[0])
      |-> sinceIn <= 4'h4)
      else $error("output moved without an input edge");
endmodule

bind ccd_channel_divider ccd_channel_divider_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk),
   .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .chInClk(chInClk), .syncHold(syncHold), .chOut(chOut));
`default_nettype wire

/* File: testbench/ccd_out_meter.sv */
// downstream clock consumer: measures output level lengths and first rise
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// output meter
// ----------------------------------------------------------------
module ccd_out_meter (
   input  wire logic        clk,
   input  wire logic        syncHold,
   input  wire logic [1:0]  chOut,
   output var  logic [1:0][15:0] riseAt,    // clks from release to first rise
   output var  logic [1:0][15:0] hiLen,     // last full high time in clks
   output var  logic [1:0][15:0] loLen      // last full low time in clks
);
   logic [15:0]      tick    = 16'h0;       // clks since sync release
   logic [1:0]       seen    = 2'b00;       // first rise already taken
   logic [1:0]       lastOut = 2'b00;       // output levels one clk ago
   logic [1:0][15:0] run     = '0;          // length of current level

   // level length and first rise bookkeeping
   always @(posedge clk) begin
      lastOut <= chOut;
      tick    <= syncHold ? 16'h0 : tick + 16'h1;
      for (int i = 0; i < 2; i++) begin
         if (chOut[i] != lastOut[i]) begin
            run[i] <= 16'h1;
            if (lastOut[i]) hiLen[i] <= run[i];
            else loLen[i] <= run[i];
            if (chOut[i] && !seen[i] && !syncHold) begin
               riseAt[i] <= tick;
               seen[i]   <= 1'b1;
            end
         end else begin
            run[i] <= run[i] + 16'h1;
         end
         if (syncHold) seen[i] <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/ccd_channel_divider_tb_top.sv */
// self-checking bench for the cascaded channel divider
`timescale 1ns/1ns
`default_nettype none
`include "ccd_map.vh"
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module ccd_channel_divider_tb_top;
   localparam int    P = 8;                 // input clock period in clks
   logic             clk      = 1'b0;
   logic             srst     = 1'b1;
   logic             psel     = 1'b0;
   logic             penable  = 1'b0;
   logic             pwrite   = 1'b0;
   logic [11:0]      paddr    = 12'h000;
   logic [31:0]      pwdata   = 32'h0;
   logic             syncHold = 1'b1;
   logic [1:0]       chInClk  = 2'b00;      // same skewed clock, both channels
   logic [2:0]       ph       = 3'h0;       // input clock phase counter
   wire  [31:0]      prdata;
   wire              pready;
   wire              pslverr;
   wire  [1:0]       chOut;
   logic [1:0][15:0] riseAt;
   logic [1:0][15:0] hiLen;
   logic [1:0][15:0] loLen;
   logic [31:0]      rv;
   logic             re;
   int               fail_count      = 0;
   int               samples_checked = 0;

   // 250 MHz clock
   initial forever #2 clk = ~clk;

   // input clock: high 3, low 5 clks
   always @(posedge clk) begin
      ph      <= ph + 3'h1;
      chInClk <= (ph < 3'h3) ? 2'b11 : 2'b00;
   end

   ccd_channel_divider #(.ADDR_W(12)) dut (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chInClk(chInClk), .syncHold(syncHold),
      .chOut(chOut));
   ccd_out_meter u_meter (.clk(clk), .syncHold(syncHold), .chOut(chOut), .riseAt(riseAt),
      .hiLen(hiLen), .loLen(loLen));

   // one apb transfer, waits for pready
   task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                          output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) fail_count++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      apbXfer(1'b1, {idx[9:0], 2'b00}, d, rv, re);
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // hold sync, program both channels, release and let outputs settle
   task automatic cfgRun(input logic [7:0] a1, a2, sa, pa, b1, b2, sb, pb, da, db);
      syncHold <= 1'b1;
      wr(`CCD_IDX_CH3_STAGE1_DIVISION, a1);
      wr(`CCD_IDX_CH3_STAGE2_DIVISION, a2);
      wr(`CCD_IDX_CH3_START_LEVEL_BYPASS, sa);
      wr(`CCD_IDX_CH3_PHASE_CODES, pa);
      wr(`CCD_IDX_CH4_STAGE1_DIVISION, b1);
      wr(`CCD_IDX_CH4_STAGE2_DIVISION, b2);
      wr(`CCD_IDX_CH4_START_LEVEL_BYPASS, sb);
      wr(`CCD_IDX_CH4_PHASE_CODES, pb);
      wr(`CCD_IDX_CH3_DUTY_FIX_DISABLE, da);
      wr(`CCD_IDX_CH4_DUTY_FIX_DISABLE, db);
      repeat (40) @(posedge clk);
      syncHold <= 1'b0;
      repeat (700) @(posedge clk);
   endtask

   task automatic conclude;
      if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      // reset values, correction enabled by default
      for (int i = 'h199; i <= 'h1a2; i++) begin
         apbXfer(1'b0, {i[9:0], 2'b00}, 8'h00, rv, re);
         check(rv, 32'h0);
      end
      apbXfer(1'b0, 12'h68c, 8'h00, rv, re);
      check({31'h0, re}, 32'h1);
      check(rv, 32'h0);
      apbXfer(1'b0, 12'h665, 8'h00, rv, re);
      check({31'h0, re}, 32'h1);
      check(rv, 32'h0);
      // status under sync: all stages preset low, sync flag set
      apbXfer(1'b0, 12'h690, 8'h00, rv, re);
      check(rv, 32'h10);
      check({31'h0, re}, 32'h0);
      // write and read back every field register except the two duty fix disable registers
      for (int i = 'h199; i <= 'h1a1; i++) begin
         if (i != 'h19d) begin
            wr(i[11:0], i[7:0] ^ 8'h5a);
            apbXfer(1'b0, {i[9:0], 2'b00}, 8'h00, rv, re);
            check(rv, {24'h0, i[7:0] ^ 8'h5a});
         end
      end
      // divide counts, cascade, correction off; second stage bypassed alone
      cfgRun(8'h21, 8'h00, 8'h20, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
      check({16'h0, hiLen[0]}, 2 * P);
      check({16'h0, loLen[0]}, 3 * P);
      check({16'h0, hiLen[1]}, 4 * P);
      check({16'h0, loLen[1]}, 4 * P);
      // phase steps on both stages of ch4 against ch3 at zero
      cfgRun(8'h11, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h12, 8'h01, 8'h01);
      check({16'h0, riseAt[1] - riseAt[0]}, 2 * P + 4 * P);
      // correction on: both bypassed, even first stage
      cfgRun(8'h00, 8'h00, 8'h30, 8'h00, 8'h11, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00);
      check({16'h0, hiLen[0]}, 3);
      check({16'h0, loLen[0]}, 5);
      check({16'h0, hiLen[1]}, 2 * P);
      check({16'h0, loLen[1]}, 2 * P);
      // odd split, correction on for ch3 and off for ch4
      cfgRun(8'h10, 8'h00, 8'h20, 8'h00, 8'h10, 8'h00, 8'h20, 8'h00, 8'h00, 8'h01);
      check({16'h0, hiLen[0]}, P + 3);
      check({16'h0, loLen[0]}, 3 * P - (P + 3));
      check({16'h0, hiLen[1]}, P);
      check({16'h0, loLen[1]}, 2 * P);
      // start high on ch4 stages against ch3 at zero, correction off
      cfgRun(8'h11, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h01, 8'h12, 8'h01, 8'h01);
      check({16'h0, riseAt[1] - riseAt[0]}, (2 + 1 + 1) * P + 1 * 4 * P);
      cfgRun(8'h11, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h02, 8'h12, 8'h01, 8'h01);
      check({16'h0, riseAt[1] - riseAt[0]}, 2 * P + (1 + 0 + 1) * 4 * P);
      cfgRun(8'h11, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h03, 8'h12, 8'h01, 8'h01);
      check({16'h0, riseAt[1] - riseAt[0]}, (2 + 1 + 1) * P + (1 + 0 + 1) * 4 * P);
      conclude();
   end
endmodule
`default_nettype wire
